// *** bench/scr_regbank_test.sv ***
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
module scr_regbank_test;
    localparam int         LIM = 2000;
    // Identity values are arbitrary
    localparam logic [7:0] FAM = 8'h6b;
    localparam logic [3:0] CHP = 4'h9;
    localparam logic [2:0] REV = 3'h5;

    logic       core_clk, rst, ce, strap, rom_req, rom_ack, rom_nak;
    logic       cfg_rd, cfg_wr, cfg_rvalid, cfg_busy, switch_start;
    logic       tag_prio_valid, prio_valid, prio_high, phy_mii_oe_n;
    logic [2:0] mode;
    logic [2:0] tag_prio;
    logic [7:0] rom_addr, rom_data, cfg_addr, cfg_wdata, cfg_rdata, gc0_value, rdat;
    int         failures, comparisons, n;
    logic [7:0] row_a [12] = '{8'h00, 8'h01, 8'h02, 8'h0c, 8'h10, 8'h1d,
                               8'h1e, 8'h2d, 8'h60, 8'h67, 8'h6d, 8'h6e};
    logic [7:0] row_e [12] = '{FAM, {CHP, REV, 1'b1}, 8'h24, 8'h00, 8'h4a, 8'h47,
                               8'h00, 8'h77, 8'h3a, 8'h3d, 8'h37, 8'h00};

    scr_regbank #(.LOAD_LIMIT_CYC(LIM), .FAMILY_CODE(FAM), .CHIP_CODE(CHP),
                  .REVISION_CODE(REV)) i_scr_regbank (
        .core_clk(core_clk), .rst(rst), .ce(ce), .interface_enable_strap_pin(strap),
        .rom_req(rom_req), .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_nak(rom_nak),
        .rom_data(rom_data), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata),
        .cfg_busy(cfg_busy), .switch_start(switch_start), .tag_prio_valid(tag_prio_valid),
        .tag_prio(tag_prio), .prio_valid(prio_valid), .prio_high(prio_high),
        .phy_mii_oe_n(phy_mii_oe_n), .gc0_value(gc0_value));

    scr_rom_model #(.FAMILY(FAM), .CHIP(CHP)) i_scr_rom_model (
        .core_clk(core_clk), .rst(rst), .mode(mode), .rom_req(rom_req),
        .rom_addr(rom_addr), .rom_ack(rom_ack), .rom_nak(rom_nak), .rom_data(rom_data));

    // ************************************************************
    // Clock, shared tasks, watchdog
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        #1 cfg_rd = 1'b1;
        cfg_addr = a;
        @(posedge core_clk);
        #1 cfg_rd = 1'b0;
        // Answer stands for one cycle only, two edges after the request
        @(posedge core_clk);
        #1 check("read valid", 8'h01, {7'h00, cfg_rvalid});
        rdat = cfg_rdata;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(posedge core_clk);
        #1 cfg_wr = 1'b0;
    endtask : wr

    // Reset, then time the load until the bank leaves busy
    task automatic boot(input logic [2:0] md, input logic st);
        mode = md;
        strap = st;
        rst = 1'b1;
        repeat (20) @(posedge core_clk);
        #1 rst = 1'b0;
        check("busy in reset", 8'h01, {7'h00, cfg_busy});
        check("no start in reset", 8'h00, {7'h00, switch_start});
        check("control in reset", 8'h4c, gc0_value);
        n = 0;
        while (cfg_busy !== 1'b0 && n < LIM + 100) begin
            @(posedge core_clk);
            #1 n++;
        end
        check("load ends in time", 8'h01, {7'h00, n <= LIM + 20});
        check("start after load", 8'h01, {7'h00, switch_start});
    endtask : boot

    task automatic test_done;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        test_done();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        failures = 0;
        comparisons = 0;
        {rst, ce, strap, cfg_rd, cfg_wr, tag_prio_valid} = 6'b111000;
        {cfg_addr, cfg_wdata, tag_prio, mode} = '0;
        boot(3'h0, 1'b1);
        check("loaded control", 8'h24, gc0_value);
        check("isolated outputs", 8'h01, {7'h00, phy_mii_oe_n});
        for (int i = 0; i < 12; i++) begin
            rd(row_a[i]);
            check($sformatf("reg %h", row_a[i]), row_e[i], rdat);
        end
        $display("test address map done");
        wr(8'h00, 8'hff);
        rd(8'h00);
        check("family after write", FAM, rdat);
        wr(8'h0c, 8'hff);
        rd(8'h0c);
        check("reserved after write", 8'h00, rdat);
        wr(8'h01, 8'h00);
        rd(8'h01);
        check("start cleared", {CHP, REV, 1'b0}, rdat);
        wr(8'h02, 8'h48);
        @(posedge core_clk);
        #1 check("outputs driven", 8'h00, {7'h00, phy_mii_oe_n});
        check("control written", 8'h48, gc0_value);
        $display("test writes done");
        for (int p = 0; p < 8; p++) begin
            @(posedge core_clk);
            #1 tag_prio_valid = 1'b1;
            tag_prio = p[2:0];
            @(posedge core_clk);
            #1 tag_prio_valid = 1'b0;
            check("prio valid", 8'h01, {7'h00, prio_valid});
            check($sformatf("prio %0d", p), {7'h00, p >= 4}, {7'h00, prio_high});
        end
        $display("test priority done");
        // A write offered while the enable is low must leave no trace
        ce = 1'b0;
        wr(8'h02, 8'h00);
        check("frozen control", 8'h48, gc0_value);
        ce = 1'b1;
        $display("test clock enable done");
        boot(3'h1, 1'b0);
        check("mismatch keeps default", 8'h44, gc0_value);
        check("strap low isolates", 8'h01, {7'h00, phy_mii_oe_n});
        $display("test identity mismatch done");
        boot(3'h2, 1'b1);
        check("absent keeps default", 8'h4c, gc0_value);
        check("strap high drives", 8'h00, {7'h00, phy_mii_oe_n});
        rd(8'h10);
        check("absent port byte", 8'h00, rdat);
        $display("test absent memory done");
        boot(3'h4, 1'b1);
        check("chip mismatch keeps default", 8'h4c, gc0_value);
        $display("test chip mismatch done");
        boot(3'h3, 1'b1);
        check("silent keeps default", 8'h4c, gc0_value);
        $display("test silent memory done");
        test_done();
    end
endmodule : scr_regbank_test

// *** bench/scr_rom_model.sv ***
// Behavioural serial configuration memory answering byte fetches
`timescale 1ns/1ps
module scr_rom_model #(
    parameter logic [7:0] FAMILY = 8'h6b,
    parameter logic [3:0] CHIP   = 4'h9
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    // 0 good image, 1 wrong family byte, 2 absent (nak), 3 never answers, 4 wrong chip code
    input  wire logic [2:0] mode,
    input  wire logic       rom_req,
    input  wire logic [7:0] rom_addr,
    output logic            rom_ack,
    output logic            rom_nak,
    output logic [7:0]      rom_data
);
    logic [7:0] a;

    // ************************************************************
    // Stored image
    // ************************************************************
    function automatic logic [7:0] image(input logic [7:0] adr, input logic [2:0] md);
        if (adr == 8'h00) begin
            return (md == 3'h1) ? ~FAMILY : FAMILY;
        end else if (adr == 8'h01) begin
            return (md == 3'h4) ? {~CHIP, 4'h1} : {CHIP, 4'h1};
        end else if (adr == 8'h02) begin
            return 8'h24;
        end
        return adr ^ 8'h5a;
    endfunction : image

    // ************************************************************
    // Answer, fast on odd addresses and slow on even ones
    // ************************************************************
    initial begin
        rom_ack  = 1'b0;
        rom_nak  = 1'b0;
        rom_data = 8'h00;
        forever begin
            @(posedge core_clk);
            if (rom_req && !rst) begin
                a = rom_addr;
                repeat (a[0] ? 1 : 6) @(posedge core_clk);
                if (mode != 3'h3) begin
                    #1;
                    rom_ack  = 1'b1;
                    rom_nak  = (mode == 3'h2);
                    rom_data = image(a, mode);
                    @(posedge core_clk);
                    #1;
                    rom_ack  = 1'b0;
                    rom_nak  = 1'b0;
                    // Released line must not keep the last byte
                    rom_data = ~rom_data;
                end
            end
        end
    end
endmodule : scr_rom_model

// *** include/scr_pkg.sv ***
// Constants, types and address decoding for the switch configuration register bank
package scr_pkg;

    // ************************************************************
    // Address map
    // ************************************************************
    localparam logic [7:0] ADDR_ID0        = 8'h00;
    localparam logic [7:0] ADDR_ID1        = 8'h01;
    localparam logic [7:0] ADDR_GC0        = 8'h02;
    localparam logic [7:0] ADDR_GC_LAST    = 8'h0b;
    localparam logic [7:0] ADDR_PORT_FIRST = 8'h10;
    localparam logic [7:0] ADDR_TOS_FIRST  = 8'h60;
    localparam logic [7:0] ADDR_TOS_LAST   = 8'h67;
    localparam logic [7:0] ADDR_LAST       = 8'h6d;
    localparam logic [3:0] PORT_STATUS_OFS = 4'he;
    localparam int         MEM_DEPTH       = 110;
    localparam int         MEM_AW          = 7;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int         ID1_CHIP_LSB    = 4;
    localparam int         ID1_REV_LSB     = 1;
    localparam int         ID1_START_BIT   = 0;
    localparam int         GC0_BASE_LSB    = 4;
    localparam int         GC0_MII_EN_BIT  = 3;
    localparam logic [7:0] GC0_RESET       = 8'h4c;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int         CLK_MHZ         = 100;
    localparam int         LOAD_TIME_MS    = 15;
    // Longest time, so the count is exact
    localparam int         LOAD_LIMIT_CYC  = LOAD_TIME_MS * 1000 * CLK_MHZ;
    localparam int         LOAD_CNT_W      = 21;
    localparam logic [1:0] STRAP_SETTLE    = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        K_NONE, K_ID0, K_ID1, K_GC0, K_MEM, K_STATUS
    } scr_kind_t;

    typedef enum logic [3:0] {
        ST_STRAP = 4'h1,
        ST_REQ   = 4'h2,
        ST_WAIT  = 4'h4,
        ST_RUN   = 4'h8
    } scr_st_t;

    typedef struct packed {
        logic [MEM_DEPTH-1:0][7:0] mem;
        logic [7:0]                rdata;
    } scr_mem_state_t;

    typedef struct packed {
        scr_st_t               st;
        logic [7:0]            addr;
        logic [LOAD_CNT_W-1:0] wd;
        logic [2:0]            sync;
        logic [1:0]            settle;
        logic                  start;
        logic [7:0]            gc0;
        logic                  busy;
        logic                  rom_req;
        logic [7:0]            rom_addr;
        logic                  rd_p1;
        logic [7:0]            rd_addr_p1;
        logic                  rvalid;
        logic [7:0]            rdata;
        logic                  prio_valid;
        logic                  prio_high;
        logic                  mii_oe_n;
    } scr_state_t;

    // Sorts a byte address into the kind of storage behind it
    function automatic scr_kind_t scr_kind(input logic [7:0] a);
        if (a == ADDR_ID0) begin
            return K_ID0;
        end else if (a == ADDR_ID1) begin
            return K_ID1;
        end else if (a == ADDR_GC0) begin
            return K_GC0;
        end else if (a <= ADDR_GC_LAST) begin
            return K_MEM;
        end else if (a < ADDR_PORT_FIRST) begin
            return K_NONE;
        end else if (a < ADDR_TOS_FIRST) begin
            // Same layout in every 16-byte port slot
            if (a[3:0] >= PORT_STATUS_OFS) begin
                return K_STATUS;
            end else begin
                return K_MEM;
            end
        end else if (a <= ADDR_LAST) begin
            return K_MEM;
        end else begin
            return K_NONE;
        end
    endfunction : scr_kind

endpackage : scr_pkg

// *** logic/scr_cfg_mem.sv ***
// Byte store for the plain read/write configuration registers
`timescale 1ns/1ps
module scr_cfg_mem (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    input  wire logic                        we,
    input  wire logic [scr_pkg::MEM_AW-1:0]  waddr,
    input  wire logic [7:0]                  wdata,
    input  wire logic [scr_pkg::MEM_AW-1:0]  raddr,
    output logic      [7:0]                  rdata
);
    scr_pkg::scr_mem_state_t s_r;
    scr_pkg::scr_mem_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = s_r.mem[raddr];
        if (we) begin
            s_nxt.mem[waddr] = wdata;
        end
    end

    // Built-in defaults are all zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
endmodule : scr_cfg_mem

// *** logic/scr_regbank.sv ***
// Configuration register bank with identity check and serial memory load
`timescale 1ns/1ps
module scr_regbank #(
    parameter int         LOAD_LIMIT_CYC = scr_pkg::LOAD_LIMIT_CYC,
    // Identity values below are arbitrary
    parameter logic [7:0] FAMILY_CODE    = 8'h5a,
    parameter logic [3:0] CHIP_CODE      = 4'h3,
    parameter logic [2:0] REVISION_CODE  = 3'h1
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       interface_enable_strap_pin,
    output logic            rom_req,
    output logic [7:0]      rom_addr,
    input  wire logic       rom_ack,
    input  wire logic       rom_nak,
    input  wire logic [7:0] rom_data,
    input  wire logic       cfg_rd,
    input  wire logic       cfg_wr,
    input  wire logic [7:0] cfg_addr,
    input  wire logic [7:0] cfg_wdata,
    output logic            cfg_rvalid,
    output logic [7:0]      cfg_rdata,
    output logic            cfg_busy,
    output logic            switch_start,
    input  wire logic       tag_prio_valid,
    input  wire logic [2:0] tag_prio,
    output logic            prio_valid,
    output logic            prio_high,
    output logic            phy_mii_oe_n,
    output logic [7:0]      gc0_value
);
    localparam int       CNT_W = scr_pkg::LOAD_CNT_W;

    scr_pkg::scr_state_t s_r;
    scr_pkg::scr_state_t s_nxt;
    logic                mem_we;
    logic [6:0]          mem_waddr;
    logic [7:0]          mem_wdata;
    logic [7:0]          mem_rdata;
    scr_pkg::scr_kind_t  ld_kind;
    scr_pkg::scr_kind_t  wr_kind;
    scr_pkg::scr_kind_t  rd_kind;

    scr_cfg_mem u_mem (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .we       (mem_we),
        .waddr    (mem_waddr),
        .wdata    (mem_wdata),
        .raddr    (cfg_addr[6:0]),
        .rdata    (mem_rdata)
    );

    assign ld_kind = scr_pkg::scr_kind(s_r.addr);
    assign wr_kind = scr_pkg::scr_kind(cfg_addr);
    assign rd_kind = scr_pkg::scr_kind(s_r.rd_addr_p1);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_nxt            = s_r;
        s_nxt.rom_req    = 1'b0;
        s_nxt.rvalid     = 1'b0;
        s_nxt.rd_p1      = 1'b0;
        s_nxt.prio_valid = 1'b0;
        s_nxt.sync       = {s_r.sync[1:0], interface_enable_strap_pin};
        mem_we           = 1'b0;
        mem_waddr        = s_r.addr[6:0];
        mem_wdata        = rom_data;
        case (s_r.st)
            scr_pkg::ST_STRAP: begin
                // Strap counts only once the last two stages agree
                if (s_r.settle != scr_pkg::STRAP_SETTLE) begin
                    s_nxt.settle = s_r.settle + 2'h1;
                end else if (s_r.sync[1] == s_r.sync[2]) begin
                    s_nxt.gc0[scr_pkg::GC0_MII_EN_BIT] = s_r.sync[2];
                    s_nxt.st = scr_pkg::ST_REQ;
                end
            end
            scr_pkg::ST_REQ: begin
                s_nxt.rom_req  = 1'b1;
                s_nxt.rom_addr = s_r.addr;
                s_nxt.st       = scr_pkg::ST_WAIT;
                s_nxt.wd       = s_r.wd + 1'b1;
            end
            scr_pkg::ST_WAIT: begin
                s_nxt.wd = s_r.wd + 1'b1;
                if (rom_ack) begin
                    s_nxt.st = scr_pkg::ST_REQ;
                    s_nxt.addr = s_r.addr + 8'h01;
                    if (rom_nak) begin
                        s_nxt.st = scr_pkg::ST_RUN;
                    end else if (ld_kind == scr_pkg::K_ID0) begin
                        if (rom_data != FAMILY_CODE) begin
                            s_nxt.st = scr_pkg::ST_RUN;
                        end
                    end else if (ld_kind == scr_pkg::K_ID1) begin
                        if (rom_data[7:scr_pkg::ID1_CHIP_LSB] != CHIP_CODE) begin
                            s_nxt.st = scr_pkg::ST_RUN;
                        end
                    end else if (ld_kind == scr_pkg::K_GC0) begin
                        s_nxt.gc0 = rom_data;
                    end else if (ld_kind == scr_pkg::K_MEM) begin
                        mem_we = 1'b1;
                    end
                    if (s_r.addr == scr_pkg::ADDR_LAST) begin
                        s_nxt.st = scr_pkg::ST_RUN;
                    end
                end
                // A silent memory must not hold the switch off forever
                if (s_r.wd >= CNT_W'(LOAD_LIMIT_CYC - 2)) begin
                    s_nxt.st = scr_pkg::ST_RUN;
                end
            end
            scr_pkg::ST_RUN: begin
                if (cfg_rd) begin
                    s_nxt.rd_p1      = 1'b1;
                    s_nxt.rd_addr_p1 = cfg_addr;
                end
                if (cfg_wr) begin
                    mem_waddr = cfg_addr[6:0];
                    mem_wdata = cfg_wdata;
                    if (wr_kind == scr_pkg::K_ID1) begin
                        s_nxt.start = cfg_wdata[scr_pkg::ID1_START_BIT];
                    end else if (wr_kind == scr_pkg::K_GC0) begin
                        s_nxt.gc0 = cfg_wdata;
                    end else if (wr_kind == scr_pkg::K_MEM) begin
                        mem_we = 1'b1;
                    end
                end
            end
            default: begin
                s_nxt.st = scr_pkg::ST_RUN;
            end
        endcase
        // Load end, whatever its cause, starts the switch
        if (s_r.busy && s_nxt.st == scr_pkg::ST_RUN) begin
            s_nxt.busy  = 1'b0;
            s_nxt.start = 1'b1;
        end
        // Read answer, one cycle after the memory's registered data
        if (s_r.rd_p1) begin
            s_nxt.rvalid = 1'b1;
            if (rd_kind == scr_pkg::K_ID0) begin
                s_nxt.rdata = FAMILY_CODE;
            end else if (rd_kind == scr_pkg::K_ID1) begin
                s_nxt.rdata = {CHIP_CODE, REVISION_CODE, s_r.start};
            end else if (rd_kind == scr_pkg::K_GC0) begin
                s_nxt.rdata = s_r.gc0;
            end else if (rd_kind == scr_pkg::K_NONE) begin
                s_nxt.rdata = scr_pkg::BYTE_ZERO;
            end else begin
                s_nxt.rdata = mem_rdata;
            end
        end
        if (tag_prio_valid) begin
            s_nxt.prio_valid = 1'b1;
            s_nxt.prio_high  = tag_prio >= s_r.gc0[6:scr_pkg::GC0_BASE_LSB];
        end
        s_nxt.mii_oe_n = ~s_nxt.gc0[scr_pkg::GC0_MII_EN_BIT];
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r          <= '0;
            s_r.st       <= scr_pkg::ST_STRAP;
            s_r.gc0      <= scr_pkg::GC0_RESET;
            s_r.sync     <= 3'h7;
            s_r.busy     <= 1'b1;
            s_r.mii_oe_n <= 1'b0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign rom_req      = s_r.rom_req;
    assign rom_addr     = s_r.rom_addr;
    assign cfg_rvalid   = s_r.rvalid;
    assign cfg_rdata    = s_r.rdata;
    assign cfg_busy     = s_r.busy;
    assign switch_start = s_r.start;
    assign prio_valid   = s_r.prio_valid;
    assign prio_high    = s_r.prio_high;
    assign phy_mii_oe_n = s_r.mii_oe_n;
    assign gc0_value    = s_r.gc0;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || !ce);

    sequence rd_req_at(logic [7:0] a);
        cfg_rd && !cfg_busy && cfg_addr == a;
    endsequence

    a_family_read: assert property (rd_req_at(scr_pkg::ADDR_ID0) |-> ##2
        (cfg_rvalid && cfg_rdata == FAMILY_CODE))
        else $error("family register read wrong");
    a_chip_rev_read: assert property (rd_req_at(scr_pkg::ADDR_ID1) |-> ##2
        (cfg_rvalid && cfg_rdata[7:1] == {CHIP_CODE, REVISION_CODE}))
        else $error("chip or revision code read wrong");
    a_reserved_zero: assert property (cfg_rd && !cfg_busy && cfg_addr >= 8'h0c
        && cfg_addr < scr_pkg::ADDR_PORT_FIRST |-> ##2 cfg_rdata == scr_pkg::BYTE_ZERO)
        else $error("reserved address read not zero");
    a_mem_we_map: assert property (mem_we |-> scr_pkg::scr_kind({1'b0, mem_waddr})
        == scr_pkg::K_MEM)
        else $error("write to non-writable address");
    a_prio_class: assert property (tag_prio_valid |=> prio_valid
        && prio_high == ($past(tag_prio) >= $past(gc0_value[6:4])))
        else $error("priority class wrong");
    a_mii_isolate: assert property (phy_mii_oe_n == !gc0_value[3])
        else $error("interface enable does not match control bit");
    a_load_bound: assert property (cfg_busy |-> s_r.wd < CNT_W'(LOAD_LIMIT_CYC))
        else $error("configuration load overran its time");
    a_start_after: assert property ($fell(cfg_busy) |-> switch_start)
        else $error("switch did not start after load");
    a_nak_default: assert property (s_r.st == scr_pkg::ST_WAIT && rom_ack && rom_nak
        |=> !cfg_busy && gc0_value == $past(gc0_value))
        else $error("absent memory changed defaults");
    a_family_reject: assert property (s_r.st == scr_pkg::ST_WAIT && rom_ack && !rom_nak
        && s_r.addr == scr_pkg::ADDR_ID0 && rom_data != FAMILY_CODE |=> !cfg_busy)
        else $error("mismatched family code did not stop load");
    a_chip_reject: assert property (s_r.st == scr_pkg::ST_WAIT && rom_ack && !rom_nak
        && s_r.addr == scr_pkg::ADDR_ID1
        && rom_data[7:scr_pkg::ID1_CHIP_LSB] != CHIP_CODE |=> !cfg_busy)
        else $error("mismatched chip code did not stop load");
    a_strap_take: assert property (s_r.st == scr_pkg::ST_STRAP && s_nxt.st == scr_pkg::ST_REQ
        |=> gc0_value[3] == $past(s_r.sync[2]))
        else $error("strap not captured into enable bit");
endmodule : scr_regbank
